/* inc/rst_seq_defs.svh */
// Constants for the reset sequencer and its host-side driver
// Operation
// - Five reset sources: power, pin, soft, two PHY
// - Power-on holds internal reset about 22 ms
// - Ready reads zero until power-on reset ends
// - Pin low resets; ready zero until done
// - Reset pin pulled up, unconnected means inactive
// - Board driver holds pin low minimum width
// - Wake write sets ready within 2 ms
// - Soft reset bit self-clears after 2 us
// - Soft reset spares kept bits and bus logic
// - PHY reset bit 10 self-clears after 100 us
// - PHY control bit 15 self-clears when done
// - Chip resets start EEPROM probe, busy set
// - Host waits EEPROM busy clear before access; rst_seq_host does not wait for it
// - Host waits link status after PHY reset; rst_seq_host has no link status wait
// - Host flags ready still clear after 100 ms
// - Host only reads until ready set; rst_seq_host does not enforce it, the device drops writes until ready
// - Host reads once before writes take effect
`ifndef RST_SEQ_DEFS_SVH
`define RST_SEQ_DEFS_SVH

`define CLK_MHZ            25
`define POR_TIME_US        22000
`define POR_CYCLES         (`POR_TIME_US * `CLK_MHZ)
`define SOFT_RST_TIME_NS   2000
`define SOFT_RST_CYCLES    (`SOFT_RST_TIME_NS * `CLK_MHZ / 1000)
`define PHY_RST_TIME_US    100
`define PHY_RST_CYCLES     (`PHY_RST_TIME_US * `CLK_MHZ)
`define WAKE_TIME_US       2000
`define WAKE_CYCLES        (`WAKE_TIME_US * `CLK_MHZ)
`define WAKE_DELAY_CYCLES  64
`define PHY_REG_RST_CYCLES 250
`define EE_PROBE_CYCLES    512
`define PIN_MIN_NS         200
`define PIN_MIN_CYCLES     ((`PIN_MIN_NS * `CLK_MHZ + 999) / 1000)
`define READY_TIMEOUT_US   100000
`define READY_TIMEOUT_CYC  (`READY_TIMEOUT_US * `CLK_MHZ)

// Device register word addresses
`define ADDR_BYTE_TEST     4'h0
`define ADDR_HW_CONFIG     4'h1
`define ADDR_PWR_CTRL      4'h2
`define ADDR_EEPROM_CMD    4'h3
`define ADDR_PHY_BCR       4'h4
`define ADDR_KEPT_SCRATCH  4'h5
`define ADDR_PLAIN_SCRATCH 4'h6

// Field positions
`define BIT_SOFT_RESET     0
`define BIT_READY          0
`define BIT_PHY_RESET      10
`define BIT_SLEEP_REQ      1
`define BIT_PHY_BCR_RESET  15
`define BIT_EEPROM_BUSY    31
`define RESET_VAL          32'h0000_0000

// Host controller register byte offsets
`define HOFS_CMD           6'h00
`define HOFS_ADDR          6'h04
`define HOFS_WDATA         6'h08
`define HOFS_RDATA         6'h0C
`define HOFS_STATUS        6'h10
`define HOFS_PIN           6'h14

`endif

/* inc/rst_seq_pkg.sv */
// Types shared by the reset sequencer ends
package rst_seq_pkg;
	typedef enum logic [2:0] {
		ST_POR    = 3'b000,
		ST_RUN    = 3'b001,
		ST_SOFT   = 3'b010,
		ST_SLEEP  = 3'b011,
		ST_WAKE   = 3'b100,
		ST_PINRST = 3'b101
	} dev_state_t;

	typedef enum logic [1:0] {
		HS_IDLE = 2'b00,
		HS_REQ  = 2'b01,
		HS_DONE = 2'b10
	} host_state_t;
endpackage

/* inc/dev_link_if.sv */
// Host bus and reset pin joining the device and its host
`timescale 1ns/10ps
interface dev_link_if;
	logic        cs;        // Access strobe, one cycle
	logic        wr;        // Write when high
	logic [3:0]  addr;      // Register word address
	logic [31:0] wdata;     // Write data
	logic [31:0] rdata;     // Read data, valid one cycle after cs
	logic        rvalid;    // Read data valid pulse
	logic        rst_drv_n; // Board drives pin low when high-z otherwise
	logic        rst_oe;    // Board driver enable
	logic        hw_reset_pin_n; // Resolved pin level, pulled up

	// Pull-up: released pin reads high
	assign hw_reset_pin_n = rst_oe ? rst_drv_n : 1'b1;

	modport device (input cs, wr, addr, wdata, hw_reset_pin_n, output rdata, rvalid);
	modport host   (output cs, wr, addr, wdata, rst_drv_n, rst_oe, input rdata, rvalid);
endinterface

/* src/rst_seq_device.sv */
// Device end: reset sequencer with ready flag and self-clearing reset bits
`timescale 1ns/10ps
`include "rst_seq_defs.svh"
module rst_seq_device #(
	parameter int POR_CYC   = `POR_CYCLES,
	parameter int WAKE_CYC  = `WAKE_DELAY_CYCLES,
	parameter int PHY_CYC   = `PHY_RST_CYCLES,
	parameter int PROBE_CYC = `EE_PROBE_CYCLES
) (
	input  wire logic clk_i,          // 25 MHz clock
	input  wire logic rst_i,          // Power-on reset, active high
	dev_link_if.device link,          // Host bus and reset pin
	output logic      phy_reset_o,    // Internal PHY held in reset
	output logic      core_reset_o    // Internal chip reset
);
	initial begin
		if (WAKE_CYC > `WAKE_CYCLES || POR_CYC < 1 || PHY_CYC < 1 || PROBE_CYC < 1)
			$error("rst_seq_device: bad timing parameter");
	end

	// Counters are full width so that any timing parameter fits
	localparam int CW = 32;

	rst_seq_pkg::dev_state_t st_q;
	logic [CW-1:0] cnt_q;
	logic [CW-1:0] phy_cnt_q;
	logic [CW-1:0] probe_cnt_q;
	logic          pin_q;
	logic          ready_q;
	logic          soft_bit_q;
	logic          phy_bit_q;
	logic          bcr_bit_q;
	logic          ee_busy_q;
	logic          sleep_q;
	logic          read_seen_q;
	logic [31:0]   kept_q;
	logic [31:0]   plain_q;
	logic          wr_ok;

	// Writes count only after a first read and, other than wake, once ready
	assign wr_ok = link.cs && link.wr && read_seen_q;

	// Pin sampled once; the pull-up lives in the interface
	always_ff @(posedge clk_i) begin
		if (rst_i)
			pin_q <= 1'b1;
		else
			pin_q <= link.hw_reset_pin_n;
	end

	// Chip reset sequencer: power-on, pin, soft, sleep and wake
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= rst_seq_pkg::ST_POR;
			cnt_q <= '0;
		end else if (!pin_q) begin
			st_q <= rst_seq_pkg::ST_PINRST;
			cnt_q <= '0;
		end else begin
			case (st_q)
				rst_seq_pkg::ST_POR: begin
					if (cnt_q == CW'(POR_CYC - 1)) begin
						st_q <= rst_seq_pkg::ST_RUN;
						cnt_q <= '0;
					end else
						cnt_q <= cnt_q + 1'b1;
				end
				rst_seq_pkg::ST_PINRST: st_q <= rst_seq_pkg::ST_RUN;
				rst_seq_pkg::ST_RUN: begin
					if (wr_ok && ready_q && link.addr == `ADDR_HW_CONFIG
					    && link.wdata[`BIT_SOFT_RESET]) begin
						st_q <= rst_seq_pkg::ST_SOFT;
						cnt_q <= '0;
					end else if (wr_ok && ready_q && link.addr == `ADDR_PWR_CTRL
					    && link.wdata[`BIT_SLEEP_REQ])
						st_q <= rst_seq_pkg::ST_SLEEP;
				end
				rst_seq_pkg::ST_SOFT: begin
					if (cnt_q == CW'(`SOFT_RST_CYCLES - 1)) begin
						st_q <= rst_seq_pkg::ST_RUN;
						cnt_q <= '0;
					end else
						cnt_q <= cnt_q + 1'b1;
				end
				rst_seq_pkg::ST_SLEEP: begin
					if (wr_ok && link.addr == `ADDR_BYTE_TEST) begin
						st_q <= rst_seq_pkg::ST_WAKE;
						cnt_q <= '0;
					end
				end
				rst_seq_pkg::ST_WAKE: begin
					if (cnt_q == CW'(WAKE_CYC - 1)) begin
						st_q <= rst_seq_pkg::ST_RUN;
						cnt_q <= '0;
					end else
						cnt_q <= cnt_q + 1'b1;
				end
				default: st_q <= rst_seq_pkg::ST_POR;
			endcase
		end
	end

	// Ready follows the sequencer: low in every chip reset, sleep and wake, but not in PHY resets
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ready_q <= 1'b0;
		else
			ready_q <= pin_q && (st_q == rst_seq_pkg::ST_RUN);
	end

	// Soft bit and chip reset output decode the state, so they need no flops of their own
	assign soft_bit_q = (st_q == rst_seq_pkg::ST_SOFT);
	assign core_reset_o = (st_q == rst_seq_pkg::ST_POR) || (st_q == rst_seq_pkg::ST_PINRST)
	                      || soft_bit_q;

	// First read after power-on reset, pin reset or wake unlocks writes; soft reset keeps writes unlocked
	always_ff @(posedge clk_i) begin
		if (rst_i || !pin_q || st_q == rst_seq_pkg::ST_WAKE)
			read_seen_q <= 1'b0;
		else if (link.cs && !link.wr)
			read_seen_q <= 1'b1;
	end

	// EEPROM probe after chip-level resets; busy held while probing
	always_ff @(posedge clk_i) begin
		if (rst_i || core_reset_o) begin
			ee_busy_q <= 1'b1;
			probe_cnt_q <= '0;
		end else if (ee_busy_q) begin
			if (probe_cnt_q == CW'(PROBE_CYC - 1))
				ee_busy_q <= 1'b0;
			else
				probe_cnt_q <= probe_cnt_q + 1'b1;
		end
	end

	// PHY resets from the power control bit and the PHY control bit
	// One counter serves both bits; a new request restarts it
	always_ff @(posedge clk_i) begin
		if (rst_i || !pin_q) begin
			phy_bit_q <= 1'b0;
			bcr_bit_q <= 1'b0;
			phy_cnt_q <= '0;
		end else if (wr_ok && ready_q && link.addr == `ADDR_PWR_CTRL
		             && link.wdata[`BIT_PHY_RESET]) begin
			phy_bit_q <= 1'b1;
			phy_cnt_q <= '0;
		end else if (wr_ok && ready_q && link.addr == `ADDR_PHY_BCR
		             && link.wdata[`BIT_PHY_BCR_RESET]) begin
			bcr_bit_q <= 1'b1;
			phy_cnt_q <= '0;
		end else if (phy_bit_q) begin
			if (phy_cnt_q == CW'(PHY_CYC - 1))
				phy_bit_q <= 1'b0;
			else
				phy_cnt_q <= phy_cnt_q + 1'b1;
		end else if (bcr_bit_q) begin
			if (phy_cnt_q == CW'(`PHY_REG_RST_CYCLES - 1))
				bcr_bit_q <= 1'b0;
			else
				phy_cnt_q <= phy_cnt_q + 1'b1;
		end
	end

	assign phy_reset_o = phy_bit_q || bcr_bit_q || (st_q == rst_seq_pkg::ST_POR)
	                     || (st_q == rst_seq_pkg::ST_PINRST);

	// Kept register survives soft reset; plain one does not
	always_ff @(posedge clk_i) begin
		if (rst_i || st_q == rst_seq_pkg::ST_PINRST)
			kept_q <= `RESET_VAL;
		else if (wr_ok && ready_q && link.addr == `ADDR_KEPT_SCRATCH)
			kept_q <= link.wdata;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || core_reset_o)
			plain_q <= `RESET_VAL;
		else if (wr_ok && ready_q && link.addr == `ADDR_PLAIN_SCRATCH)
			plain_q <= link.wdata;
	end

	// Read path is bus logic: not cleared by soft reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			link.rdata <= '0;
			link.rvalid <= 1'b0;
		end else begin
			link.rvalid <= link.cs && !link.wr;
			if (link.cs && !link.wr) begin
				case (link.addr)
					`ADDR_BYTE_TEST:     link.rdata <= 32'h8765_4321;
					`ADDR_HW_CONFIG:     link.rdata <= {31'h0, soft_bit_q};
					`ADDR_PWR_CTRL:      link.rdata <= {21'h0, phy_bit_q, 8'h0,
					                                    sleep_q, ready_q};
					`ADDR_EEPROM_CMD:    link.rdata <= {ee_busy_q, 31'h0};
					`ADDR_PHY_BCR:       link.rdata <= {16'h0, bcr_bit_q, 15'h0};
					`ADDR_KEPT_SCRATCH:  link.rdata <= kept_q;
					`ADDR_PLAIN_SCRATCH: link.rdata <= plain_q;
					default:             link.rdata <= '0;
				endcase
			end
		end
	end

	// Asleep reads back from the state; only a byte test write wakes it
	assign sleep_q = (st_q == rst_seq_pkg::ST_SLEEP);
endmodule

/* src/rst_seq_host.sv */
// Host end: Wishbone-controlled master of the device bus and reset pin
`timescale 1ns/10ps
`include "rst_seq_defs.svh"
module rst_seq_host #(
	parameter int TIMEOUT_CYC = `READY_TIMEOUT_CYC,
	parameter int PIN_CYC     = `PIN_MIN_CYCLES
) (
	input  wire logic        clk_i,   // 25 MHz clock
	input  wire logic        rst_i,   // Synchronous reset, active high
	input  wire logic        cyc_i,   // Wishbone cycle
	input  wire logic        stb_i,   // Wishbone strobe
	input  wire logic        we_i,    // Wishbone write
	input  wire logic [5:0]  adr_i,   // Wishbone byte address
	input  wire logic [3:0]  sel_i,   // Wishbone byte selects
	input  wire logic [31:0] dat_i,   // Wishbone write data
	output logic [31:0]      dat_o,   // Wishbone read data
	output logic             ack_o,   // Wishbone acknowledge
	dev_link_if.host         link     // Device bus and reset pin
);
	initial begin
		if (PIN_CYC < 1 || TIMEOUT_CYC < 1)
			$error("rst_seq_host: bad timing parameter");
	end

	rst_seq_pkg::host_state_t hs_q;
	logic [3:0]  addr_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_q;
	logic        is_wr_q;
	logic        done_q;
	logic        err_q;
	logic [31:0] pin_cnt_q;
	logic [31:0] to_cnt_q;
	logic        ready_seen_q;
	logic        wb_wr;
	logic        req_go;

	assign wb_wr  = cyc_i && stb_i && we_i && !ack_o && sel_i == 4'hF;
	assign req_go = wb_wr && adr_i == `HOFS_CMD && hs_q == rst_seq_pkg::HS_IDLE;

	// Ack one cycle after the request; dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_o <= 1'b0;
		else
			ack_o <= cyc_i && stb_i && !ack_o;
	end

	// Command registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			addr_q <= '0;
			wdata_q <= '0;
			is_wr_q <= 1'b0;
		end else begin
			if (wb_wr && adr_i == `HOFS_ADDR)
				addr_q <= dat_i[3:0];
			if (wb_wr && adr_i == `HOFS_WDATA)
				wdata_q <= dat_i;
			if (req_go)
				is_wr_q <= dat_i[1];
		end
	end

	// Single device access: strobe one cycle, wait for read data
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hs_q <= rst_seq_pkg::HS_IDLE;
			link.cs <= 1'b0;
			link.wr <= 1'b0;
			link.addr <= '0;
			link.wdata <= '0;
			rdata_q <= '0;
			done_q <= 1'b0;
		end else begin
			link.cs <= 1'b0;
			case (hs_q)
				rst_seq_pkg::HS_IDLE: begin
					if (req_go && dat_i[0]) begin
						link.cs <= 1'b1;
						link.wr <= dat_i[1];
						link.addr <= addr_q;
						link.wdata <= wdata_q;
						done_q <= 1'b0;
						hs_q <= rst_seq_pkg::HS_REQ;
					end
				end
				rst_seq_pkg::HS_REQ: begin
					if (!is_wr_q) begin
						hs_q <= rst_seq_pkg::HS_DONE;
					end else begin
						done_q <= 1'b1;
						hs_q <= rst_seq_pkg::HS_IDLE;
					end
				end
				rst_seq_pkg::HS_DONE: begin
					if (link.rvalid) begin
						rdata_q <= link.rdata;
						done_q <= 1'b1;
						hs_q <= rst_seq_pkg::HS_IDLE;
					end
				end
				default: hs_q <= rst_seq_pkg::HS_IDLE;
			endcase
		end
	end

	// Board reset driver holds the pin low for at least the minimum width
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_cnt_q <= '0;
			link.rst_oe <= 1'b0;
			link.rst_drv_n <= 1'b1;
		end else if (wb_wr && adr_i == `HOFS_PIN && dat_i[0]) begin
			pin_cnt_q <= 32'(PIN_CYC);
			link.rst_oe <= 1'b1;
			link.rst_drv_n <= 1'b0;
		end else if (pin_cnt_q != '0) begin
			pin_cnt_q <= pin_cnt_q - 1'b1;
		end else begin
			link.rst_oe <= 1'b0;
			link.rst_drv_n <= 1'b1;
		end
	end

	// Ready watchdog: ready not seen set by a read for too long is an error, even with no read at all
	always_ff @(posedge clk_i) begin
		if (rst_i || (wb_wr && adr_i == `HOFS_STATUS)) begin
			to_cnt_q <= '0;
			err_q <= 1'b0;
			ready_seen_q <= 1'b0;
		end else begin
			if (link.rvalid && link.addr == `ADDR_PWR_CTRL)
				ready_seen_q <= link.rdata[`BIT_READY];
			if (ready_seen_q)
				to_cnt_q <= '0;
			else if (to_cnt_q == 32'(TIMEOUT_CYC - 1))
				err_q <= 1'b1;
			else
				to_cnt_q <= to_cnt_q + 1'b1;
		end
	end

	// Wishbone read mux
	always_ff @(posedge clk_i) begin
		if (rst_i)
			dat_o <= '0;
		else begin
			case (adr_i)
				`HOFS_CMD:    dat_o <= {30'h0, is_wr_q, hs_q != rst_seq_pkg::HS_IDLE};
				`HOFS_ADDR:   dat_o <= {28'h0, addr_q};
				`HOFS_WDATA:  dat_o <= wdata_q;
				`HOFS_RDATA:  dat_o <= rdata_q;
				`HOFS_STATUS: dat_o <= {29'h0, err_q, ready_seen_q, done_q};
				`HOFS_PIN:    dat_o <= {31'h0, link.rst_oe};
				default:      dat_o <= '0;
			endcase
		end
	end
endmodule

/* tb/rst_seq_assertions.sv */
// Concurrent checks on the link between host and device ends
`timescale 1ns/10ps
module rst_seq_assertions (
	input wire logic        clk_i,          // Clock
	input wire logic        rst_i,          // Reset, active high
	input wire logic        cs,             // Access strobe
	input wire logic        wr,             // Write when high
	input wire logic [31:0] rdata,          // Read data
	input wire logic        rvalid,         // Read data valid
	input wire logic        rst_oe,         // Pin driver enable
	input wire logic        hw_reset_pin_n, // Resolved pin level
	input wire logic        phy_reset_o,    // PHY held in reset
	input wire logic        core_reset_o    // Chip reset
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// Bus logic answers reads even while a soft reset runs
	chk_read_answer: assert property (cs && !wr && hw_reset_pin_n |=> rvalid)
		else $error("read not answered");
	chk_write_silent: assert property (cs && wr |=> !rvalid)
		else $error("write gave read valid");
	chk_no_stray: assert property (rvalid |-> $past(cs) && !$past(wr))
		else $error("read valid without read");
	chk_data_holds: assert property (!$stable(rdata) && hw_reset_pin_n
		&& $past(hw_reset_pin_n) |-> rvalid)
		else $error("read data changed without read");
	// Power-on count holds the chip in reset, then lets go
	chk_por_hold: assert property ($fell(rst_i) |-> core_reset_o[*8] ##[1:40] !core_reset_o)
		else $error("power-on reset length wrong");
	chk_pin_resets: assert property (!hw_reset_pin_n |-> ##[1:2] core_reset_o)
		else $error("pin low did not reset");
	chk_pin_width: assert property ($rose(rst_oe) |-> (!hw_reset_pin_n)[*5])
		else $error("pin pulse too short");
	chk_pin_pullup: assert property (!rst_oe |-> hw_reset_pin_n)
		else $error("released pin not high");
	chk_phy_hold: assert property ($rose(phy_reset_o) |-> phy_reset_o[*4])
		else $error("PHY reset too short");
endmodule

/* tb/ethernet_ctrl_reset_sequencer_tb.sv */
// Testbench driving the host end over Wishbone against the device end
`timescale 1ns/10ps
`include "rst_seq_defs.svh"
module ethernet_ctrl_reset_sequencer_tb;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [5:0]  adr;
	logic [31:0] dat_w;
	logic [3:0]  sel;
	logic [31:0] dat_r;
	logic        ack;
	logic        phy_rst;
	logic        core_rst;
	logic [31:0] q;
	int          n;
	int          error_cnt;
	int          check_count;
	int          core_cnt;
	int          core_run;
	int          phy_cnt;
	int          phy_run;

	dev_link_if link ();
	rst_seq_device #(.POR_CYC(40), .PHY_CYC(10), .PROBE_CYC(8)) u_rst_seq_device (
		.clk_i(clk_i), .rst_i(rst_i), .link(link), .phy_reset_o(phy_rst), .core_reset_o(core_rst));
	rst_seq_host #(.TIMEOUT_CYC(200), .PIN_CYC(5)) u_rst_seq_host (.clk_i(clk_i), .rst_i(rst_i),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat_w),
		.dat_o(dat_r), .ack_o(ack), .link(link));
	rst_seq_assertions u_rst_seq_assertions (.clk_i(clk_i), .rst_i(rst_i), .cs(link.cs),
		.wr(link.wr), .rdata(link.rdata), .rvalid(link.rvalid), .rst_oe(link.rst_oe),
		.hw_reset_pin_n(link.hw_reset_pin_n), .phy_reset_o(phy_rst), .core_reset_o(core_rst));

	// Clock, 40 ns period
	initial begin
		clk_i = 1'h0;
		forever #20 clk_i = ~clk_i;
	end

	// Length of the latest high run of each reset output
	always @(posedge clk_i) begin
		core_cnt <= (rst_i || !core_rst) ? 0 : core_cnt + 1;
		phy_cnt <= (rst_i || !phy_rst) ? 0 : phy_cnt + 1;
		if (!core_rst && core_cnt != 0)
			core_run <= core_cnt;
		if (!phy_rst && phy_cnt != 0)
			phy_run <= phy_cnt;
	end

	task automatic report_and_stop;
		if (error_cnt == 0 && check_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic cmp_bit(input logic g, input logic e);
		cmp({31'h0, g}, {31'h0, e});
	endtask

	// One classic Wishbone cycle; held until ack is sampled high
	task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
		output logic [31:0] r);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		dat_w <= d;
		do begin
			@(posedge clk_i);
			k++;
		end while (ack !== 1'h1 && k < 20);
		if (k >= 20)
			error_cnt++;
		r = dat_r;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask

	// One device access through the host command registers
	task automatic dev(input logic w, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] r);
		logic [31:0] s;
		int          k;
		wb(1'h1, `HOFS_ADDR, {28'h0, a}, s);
		wb(1'h1, `HOFS_WDATA, d, s);
		wb(1'h1, `HOFS_CMD, {30'h0, w, 1'h1}, s);
		k = 0;
		do begin
			wb(1'h0, `HOFS_CMD, 32'h0, s);
			k++;
		end while (s[0] !== 1'h0 && k < 20);
		if (k >= 20)
			error_cnt++;
		wb(1'h0, `HOFS_RDATA, 32'h0, r);
	endtask

	// Poll ready; the polls are also the reads that re-enable writes
	task automatic wait_ready(output int k);
		k = 0;
		do begin
			dev(1'h0, `ADDR_PWR_CTRL, 32'h0, q);
			k++;
		end while (q[0] !== 1'h1 && k < 20);
		cmp_bit(q[0], 1'h1);
	endtask

	// Watchdog, far beyond the expected run of well under two thousand cycles
	initial begin
		repeat (20000) @(posedge clk_i);
		error_cnt++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		{rst_i, cyc, stb, we, adr, dat_w, error_cnt, check_count} = '0;
		sel = 4'hF;
		rst_i = 1'h1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'h0;
		dev(1'h0, `ADDR_EEPROM_CMD, 32'h0, q);
		cmp_bit(q[31], 1'h1);
		dev(1'h0, `ADDR_PWR_CTRL, 32'h0, q);
		cmp_bit(q[0], 1'h0);
		wait_ready(n);
		cmp_bit(core_run inside {[40:41]}, 1'h1);
		dev(1'h0, `ADDR_EEPROM_CMD, 32'h0, q);
		cmp_bit(q[31], 1'h0);
		dev(1'h0, `ADDR_BYTE_TEST, 32'h0, q);
		cmp(q, 32'h8765_4321);
		dev(1'h1, `ADDR_KEPT_SCRATCH, 32'h1111_2222, q);
		dev(1'h1, `ADDR_PLAIN_SCRATCH, 32'h3333_4444, q);
		// Soft reset: bit reads set, then clears by itself
		dev(1'h1, `ADDR_HW_CONFIG, 32'h1, q);
		dev(1'h0, `ADDR_HW_CONFIG, 32'h0, q);
		cmp_bit(q[0], 1'h1);
		repeat (60) @(posedge clk_i);
		dev(1'h0, `ADDR_HW_CONFIG, 32'h0, q);
		cmp_bit(q[0], 1'h0);
		cmp_bit(core_run inside {[50:51]}, 1'h1);
		dev(1'h0, `ADDR_KEPT_SCRATCH, 32'h0, q);
		cmp(q, 32'h1111_2222);
		dev(1'h0, `ADDR_PLAIN_SCRATCH, 32'h0, q);
		cmp(q, 32'h0);
		// Pin reset; a write before any read must be lost
		wb(1'h1, `HOFS_PIN, 32'h1, q);
		dev(1'h1, `ADDR_PLAIN_SCRATCH, 32'h7777_8888, q);
		wait_ready(n);
		dev(1'h0, `ADDR_PLAIN_SCRATCH, 32'h0, q);
		cmp(q, 32'h0);
		dev(1'h0, `ADDR_KEPT_SCRATCH, 32'h0, q);
		cmp(q, 32'h0);
		dev(1'h1, `ADDR_PLAIN_SCRATCH, 32'h9999_AAAA, q);
		dev(1'h0, `ADDR_PLAIN_SCRATCH, 32'h0, q);
		cmp(q, 32'h9999_AAAA);
		// Sleep, refused write, wake through byte test
		dev(1'h1, `ADDR_PWR_CTRL, 32'h2, q);
		dev(1'h0, `ADDR_PWR_CTRL, 32'h0, q);
		cmp({30'h0, q[1:0]}, 32'h2);
		dev(1'h1, `ADDR_PLAIN_SCRATCH, 32'h1234_5678, q);
		dev(1'h1, `ADDR_BYTE_TEST, 32'h0, q);
		wait_ready(n);
		cmp_bit(n <= 8, 1'h1);
		dev(1'h0, `ADDR_PLAIN_SCRATCH, 32'h0, q);
		cmp(q, 32'h9999_AAAA);
		// PHY reset through power control
		dev(1'h1, `ADDR_PWR_CTRL, 32'h400, q);
		repeat (30) @(posedge clk_i);
		cmp_bit(phy_run inside {[10:11]}, 1'h1);
		dev(1'h0, `ADDR_PWR_CTRL, 32'h0, q);
		cmp_bit(q[10], 1'h0);
		// PHY reset through the PHY control word
		dev(1'h1, `ADDR_PHY_BCR, 32'h8000, q);
		dev(1'h0, `ADDR_PHY_BCR, 32'h0, q);
		cmp_bit(q[15], 1'h1);
		repeat (300) @(posedge clk_i);
		dev(1'h0, `ADDR_PHY_BCR, 32'h0, q);
		cmp_bit(q[15], 1'h0);
		// Ready never seen for longer than the host limit flags an error
		wb(1'h1, `HOFS_STATUS, 32'h0, q);
		repeat (210) @(posedge clk_i);
		wb(1'h0, `HOFS_STATUS, 32'h0, q);
		cmp(q, 32'h5);
		// Partial byte selects are refused but still acknowledged
		wb(1'h1, `HOFS_ADDR, 32'h5, q);
		sel <= 4'h3;
		wb(1'h1, `HOFS_ADDR, 32'hA, q);
		sel <= 4'hF;
		wb(1'h0, `HOFS_ADDR, 32'h0, q);
		cmp(q, 32'h5);
		// Unmapped host offset must still be acknowledged
		wb(1'h1, 6'h18, 32'h0, q);
		wb(1'h0, 6'h18, 32'h0, q);
		report_and_stop();
	end
endmodule
